// ===== common/vks_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef VKS_MAP_VH
`define VKS_MAP_VH

// byte addresses on the bus, one aligned word each
`define VKS_ADR_MODE0 12'h000
`define VKS_ADR_MODE1 12'h004
`define VKS_ADR_PORT8 12'h008
`define VKS_ADR_PORT9 12'h00c
`define VKS_ADR_PORT10 12'h010
`define VKS_ADR_PORT11 12'h014
`define VKS_ADR_PORT12 12'h018
`define VKS_ADR_INT_STAT 12'h020
`define VKS_ADR_INT_MASK 12'h024
`define VKS_ADR_MEM_BASE 12'h100
`define VKS_ADR_MEM_LAST 12'h23c

// display data memory, device addresses
`define VKS_MEM_FIRST 16'hfa30
`define VKS_MEM_LAST 16'hfa7f
`define VKS_MEM_WORDS 80
`define VKS_MEM_TOP_COL 7'h40
`define VKS_MEM_COL_STEP 7'h10

// display mode register 0 fields
`define VKS_M0_KEY_FLAG 7
`define VKS_M0_TYPE_SEL 5
`define VKS_M0_ENABLE 0
`define VKS_M0_WR_MASK 8'h21
`define VKS_M0_RESET 8'h00

// display mode register 1: blanking time in microseconds
`define VKS_M1_RESET 8'h14

// interrupt status bits
`define VKS_INT_KEY_START 0
`define VKS_INT_KEY_END 1
`define VKS_INT_BITS 2

// timing
`define VKS_CLK_MHZ 100
`define VKS_TICK_US 1
`define VKS_TICK_CYC (`VKS_CLK_MHZ * `VKS_TICK_US)
`define VKS_SHOW_US 60
`define VKS_KEY_US 60

`endif

// ===== verilog/vks_ctrl.v
// key-scan slot sequencer, display mode registers and display memory
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "vks_map.vh"


module vks_ctrl #(
    parameter SEG_N = 10,
    parameter DIG_N = 11,
    parameter SHOW_US = `VKS_SHOW_US,
    parameter KEY_US = `VKS_KEY_US
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg [SEG_N-1:0] segment_outputs_o,
    output reg [DIG_N-1:0] digit_outputs_o,
    output reg [39:0] shared_display_output_pins_o,
    output wire key_scan_slot_o,
    output wire irq_o
);

    localparam NBYTES = (SEG_N + 7) / 8;
    localparam ST_IDLE = 4'b0001;
    localparam ST_BLANK = 4'b0010;
    localparam ST_SHOW = 4'b0100;
    localparam ST_KEY = 4'b1000;
    // counts are worked out at full width, then cut to the counter size
    localparam integer SHOW_END = SHOW_US - 1;
    localparam integer KEY_END = KEY_US - 1;
    localparam integer TICK_END = `VKS_TICK_CYC - 1;
    localparam integer NBYTES_I = NBYTES;
    localparam integer DIG_END = DIG_N - 1;
    localparam [7:0] SHOW_LAST = SHOW_END[7:0];
    localparam [7:0] KEY_LAST = KEY_END[7:0];
    localparam [6:0] TICK_LAST = TICK_END[6:0];
    localparam [2:0] NBYTES_W = NBYTES_I[2:0];
    localparam [4:0] DIG_LAST = DIG_END[4:0];

    reg [7:0] mem [0:`VKS_MEM_WORDS-1];
    reg [7:0] mode0_reg;
    reg [7:0] mode1_reg;
    reg [7:0] port_reg [0:4];
    reg [`VKS_INT_BITS-1:0] int_stat_reg;
    reg [`VKS_INT_BITS-1:0] int_mask_reg;
    reg [3:0] state_reg;
    reg [4:0] dig_reg;
    reg [2:0] fcol_reg;
    reg [7:0] tcnt_reg;
    reg [6:0] div_reg;
    reg [39:0] seg_buf_reg;
    reg ev_start;
    reg ev_end;

    // one-hot grid select; a digit past DIG_N-1 gives an all-off bus
    function [DIG_N-1:0] digit_bit;
        input [4:0] d;
        begin
            digit_bit = {{(DIG_N-1){1'b0}}, 1'b1} << d;
        end
    endfunction

    // column k of digit d sits at 0x40 - 0x10*k + d above the base
    function [6:0] fetch_addr;
        input [2:0] col;
        input [4:0] d;
        begin
            fetch_addr = `VKS_MEM_TOP_COL - {col, 4'h0} + {2'b00, d};
        end
    endfunction

    // a held request is acked every other cycle: ack masks it off for the next edge
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_lo = bus_req & wb_we_i & wb_sel_i[0];
    wire mem_hit = (wb_adr_i >= `VKS_ADR_MEM_BASE) &&
        (wb_adr_i <= `VKS_ADR_MEM_LAST);
    wire [11:0] mem_off = wb_adr_i - `VKS_ADR_MEM_BASE;
    wire [6:0] mem_idx = mem_off[8:2];
    wire tick = (div_reg == TICK_LAST);
    wire key_flag = state_reg[3];
    wire enabled = mode0_reg[`VKS_M0_ENABLE];
    // a zero blanking count is treated as one microsecond
    wire [7:0] blank_last = (mode1_reg == 8'h00) ? 8'h00 :
        mode1_reg - 8'h01;
    wire [6:0] fetch_idx = fetch_addr(fcol_reg, dig_reg);
    wire fetch_done = (fcol_reg == NBYTES_W);
    wire [39:0] latch_cat = {port_reg[4], port_reg[3], port_reg[2],
        port_reg[1], port_reg[0]};

    assign key_scan_slot_o = key_flag;
    assign irq_o = |(int_stat_reg & int_mask_reg);

    // register writes
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode0_reg <= `VKS_M0_RESET;
            mode1_reg <= `VKS_M1_RESET;
            int_mask_reg <= {`VKS_INT_BITS{1'b0}};
            for (i = 0; i < 5; i = i + 1) begin
                port_reg[i] <= 8'h00;
            end
        end else if (wr_lo) begin
            case (wb_adr_i)
                // flag bit is not writable
                `VKS_ADR_MODE0: begin
                    mode0_reg <= wb_dat_i[7:0] & `VKS_M0_WR_MASK;
                end
                `VKS_ADR_MODE1: begin
                    mode1_reg <= wb_dat_i[7:0];
                end
                `VKS_ADR_PORT8: begin
                    port_reg[0] <= wb_dat_i[7:0];
                end
                `VKS_ADR_PORT9: begin
                    port_reg[1] <= wb_dat_i[7:0];
                end
                `VKS_ADR_PORT10: begin
                    port_reg[2] <= wb_dat_i[7:0];
                end
                `VKS_ADR_PORT11: begin
                    port_reg[3] <= wb_dat_i[7:0];
                end
                `VKS_ADR_PORT12: begin
                    port_reg[4] <= wb_dat_i[7:0];
                end
                `VKS_ADR_INT_MASK: begin
                    int_mask_reg <= wb_dat_i[`VKS_INT_BITS-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // display memory: cpu write port, unused bytes are plain RAM
    // the sequencer reads this array on its own; cpu writes never stall it
    always @(posedge clk_i) begin
        if (wr_lo && mem_hit) begin
            mem[mem_idx] <= wb_dat_i[7:0];
        end
    end

    // sticky status, a new event wins over a write-one clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            int_stat_reg <= {`VKS_INT_BITS{1'b0}};
        end else begin
            if (wr_lo && wb_adr_i == `VKS_ADR_INT_STAT) begin
                int_stat_reg <= (int_stat_reg &
                    ~wb_dat_i[`VKS_INT_BITS-1:0]) | {ev_end, ev_start};
            end else begin
                int_stat_reg <= int_stat_reg | {ev_end, ev_start};
            end
        end
    end

    // bus answer: one wait-free ack per request, reads have no side effect
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                if (mem_hit) begin
                    wb_dat_o <= {24'h000000, mem[mem_idx]};
                end else begin
                    case (wb_adr_i)
                        `VKS_ADR_MODE0: begin
                            wb_dat_o <= {24'h000000, key_flag,
                                mode0_reg[6:0]};
                        end
                        `VKS_ADR_MODE1: begin
                            wb_dat_o <= {24'h000000, mode1_reg};
                        end
                        `VKS_ADR_PORT8: begin
                            wb_dat_o <= {24'h000000, port_reg[0]};
                        end
                        `VKS_ADR_PORT9: begin
                            wb_dat_o <= {24'h000000, port_reg[1]};
                        end
                        `VKS_ADR_PORT10: begin
                            wb_dat_o <= {24'h000000, port_reg[2]};
                        end
                        `VKS_ADR_PORT11: begin
                            wb_dat_o <= {24'h000000, port_reg[3]};
                        end
                        `VKS_ADR_PORT12: begin
                            wb_dat_o <= {24'h000000, port_reg[4]};
                        end
                        `VKS_ADR_INT_STAT: begin
                            wb_dat_o <= {30'h00000000, int_stat_reg};
                        end
                        `VKS_ADR_INT_MASK: begin
                            wb_dat_o <= {30'h00000000, int_mask_reg};
                        end
                        default: begin
                            wb_dat_o <= 32'h00000000;
                        end
                    endcase
                end
            end
        end
    end

    // microsecond tick
    // the divider runs free, so the first blanking after enable may run up to one tick short
    always @(posedge clk_i) begin
        if (rst_i || tick) begin
            div_reg <= 7'h00;
        end else begin
            div_reg <= div_reg + 7'h01;
        end
    end

    // digit sequencer: blank+fetch, show, ..., last digit, key slot
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            dig_reg <= 5'h00;
            fcol_reg <= 3'h0;
            tcnt_reg <= 8'h00;
            seg_buf_reg <= 40'h0000000000;
            ev_start <= 1'b0;
            ev_end <= 1'b0;
        end else begin
            ev_start <= 1'b0;
            ev_end <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    dig_reg <= 5'h00;
                    fcol_reg <= 3'h0;
                    tcnt_reg <= 8'h00;
                    if (enabled) begin
                        state_reg <= ST_BLANK;
                    end
                end
                ST_BLANK: begin
                    // one column byte per cycle, highest column first
                    if (!fetch_done) begin
                        seg_buf_reg[39 - 8 * fcol_reg -: 8] <=
                            mem[fetch_idx];
                        fcol_reg <= fcol_reg + 3'h1;
                    end
                    if (tick) begin
                        tcnt_reg <= tcnt_reg + 8'h01;
                    end
                    if (!enabled) begin
                        state_reg <= ST_IDLE;
                    end else if (tick && fetch_done &&
                            tcnt_reg >= blank_last) begin
                        tcnt_reg <= 8'h00;
                        state_reg <= ST_SHOW;
                    end
                end
                ST_SHOW: begin
                    if (tick) begin
                        tcnt_reg <= tcnt_reg + 8'h01;
                    end
                    if (!enabled) begin
                        state_reg <= ST_IDLE;
                    end else if (tick && tcnt_reg == SHOW_LAST) begin
                        tcnt_reg <= 8'h00;
                        fcol_reg <= 3'h0;
                        if (dig_reg == DIG_LAST) begin
                            state_reg <= ST_KEY;
                            ev_start <= 1'b1;
                        end else begin
                            dig_reg <= dig_reg + 5'h01;
                            state_reg <= ST_BLANK;
                        end
                    end
                end
                ST_KEY: begin
                    if (tick) begin
                        tcnt_reg <= tcnt_reg + 8'h01;
                    end
                    if (!enabled) begin
                        ev_end <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else if (tick && tcnt_reg == KEY_LAST) begin
                        // flag drops as digit timing resumes
                        tcnt_reg <= 8'h00;
                        dig_reg <= 5'h00;
                        ev_end <= 1'b1;
                        state_reg <= ST_BLANK;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // output drivers; mode 2 shares the mode 1 fetch path here
    always @(posedge clk_i) begin
        if (rst_i) begin
            segment_outputs_o <= {SEG_N{1'b0}};
            digit_outputs_o <= {DIG_N{1'b0}};
            shared_display_output_pins_o <= 40'h0000000000;
        end else if (state_reg == ST_SHOW) begin
            segment_outputs_o <= seg_buf_reg[39 -: SEG_N];
            digit_outputs_o <= digit_bit(dig_reg);
            shared_display_output_pins_o <= {latch_cat[39:SEG_N],
                seg_buf_reg[39 -: SEG_N]};
        end else if (state_reg == ST_KEY) begin
            segment_outputs_o <= {SEG_N{1'b0}};
            digit_outputs_o <= {DIG_N{1'b0}};
            // latches are read live, so port 11/12 rewrites step the scan
            shared_display_output_pins_o <= latch_cat;
        end else begin
            // blanking keeps the next grid off until segments fall
            segment_outputs_o <= {SEG_N{1'b0}};
            digit_outputs_o <= {DIG_N{1'b0}};
            shared_display_output_pins_o <= {latch_cat[39:SEG_N],
                {SEG_N{1'b0}}};
        end
    end

endmodule
`default_nettype wire

// ===== bench/vks_ctrl_checker.sv
// concurrent checks on the key-scan display controller ports
`timescale 1ns/1ps
`default_nettype none
module vks_ctrl_checker #(
    parameter SEG_N = 10,
    parameter DIG_N = 11,
    parameter KEY_US = 60
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [SEG_N-1:0] segment_outputs_o,
    input wire logic [DIG_N-1:0] digit_outputs_o,
    input wire logic key_scan_slot_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] slot_cnt;
    // one tick is 100 clocks, so a slot never outlasts KEY_US ticks
    always @(posedge clk_i) begin
        if (rst_i || !key_scan_slot_o) slot_cnt <= 32'h0;
        else slot_cnt <= slot_cnt + 32'h1;
    end
    a_key_lines_off: assert property (key_scan_slot_o &&
        $past(key_scan_slot_o) |-> segment_outputs_o == 0 &&
        digit_outputs_o == 0) else $error("display lines on in key slot");
    a_digit_one_hot: assert property ($onehot0(digit_outputs_o))
        else $error("more than one digit on");
    a_seg_needs_digit: assert property (segment_outputs_o != 0
        |-> digit_outputs_o != 0) else $error("segments without digit");
    a_slot_bounded: assert property (key_scan_slot_o
        |-> slot_cnt <= KEY_US * 100) else $error("key slot too long");
    a_flag_read: assert property ($past(wb_cyc_i && wb_stb_i &&
        !wb_ack_o && !wb_we_i && wb_adr_i == 12'h000) |->
        wb_dat_o[7] == $past(key_scan_slot_o)) else $error("flag read");
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    cover property ($rose(key_scan_slot_o));
    cover property ($fell(key_scan_slot_o));
    cover property (wb_ack_o && !wb_we_i && key_scan_slot_o);
endmodule
bind vks_ctrl vks_ctrl_checker #(.SEG_N(SEG_N), .DIG_N(DIG_N),
    .KEY_US(KEY_US)) vks_ctrl_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .segment_outputs_o(segment_outputs_o),
    .digit_outputs_o(digit_outputs_o), .key_scan_slot_o(key_scan_slot_o));
`default_nettype wire

// ===== bench/vks_panel.sv
// display panel model: remembers the segments lit at each grid
`timescale 1ns/1ps
`default_nettype none
module vks_panel #(parameter SEG_N = 10, parameter DIG_N = 11) (
    input wire logic clk_i,
    input wire logic [SEG_N-1:0] seg_i,
    input wire logic [DIG_N-1:0] dig_i,
    output logic [DIG_N-1:0][SEG_N-1:0] lit_o
);
    always @(posedge clk_i) begin
        for (int d = 0; d < DIG_N; d++) begin
            if (dig_i[d]) lit_o[d] <= seg_i;
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the key-scan display controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
    typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e;} vks_row_t;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [11:0] adr = 0;
    logic [31:0] wdat = 0, q;
    wire [31:0] rdat;
    wire ack, irq, slot;
    wire [9:0] seg;
    wire [10:0] dig;
    wire [39:0] pins;
    wire [10:0][9:0] lit;
    int fails = 0, n_compared = 0, cycles = 0;
    // port patterns are one walking bit per latch byte, so each byte shows apart on the key pins
    vks_row_t rows[10] = '{'{12'h004, 8'h14, 8'h14}, '{12'h008, 8'h01, 8'h01},
        '{12'h00c, 8'h02, 8'h02}, '{12'h010, 8'h04, 8'h04},
        '{12'h014, 8'h08, 8'h08}, '{12'h018, 8'h10, 8'h10},
        '{12'h024, 8'h03, 8'h03}, '{12'h030, 8'hff, 8'h00},
        '{12'h23c, 8'h5c, 8'h5c}, '{12'h000, 8'hfe, 8'h20}};
    vks_ctrl #(.SHOW_US(2), .KEY_US(2)) vks_ctrl_inst (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .segment_outputs_o(seg), .digit_outputs_o(dig),
        .shared_display_output_pins_o(pins), .key_scan_slot_o(slot),
        .irq_o(irq));
    vks_panel vks_panel_inst (.clk_i(clk_i), .seg_i(seg), .dig_i(dig),
        .lit_o(lit));
    always #5 clk_i = ~clk_i;
    task automatic wb(input logic [11:0] a, input logic w,
        input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        // the request stands until ack is seen high at a rising edge
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic wait_slot(input logic l);
        while (slot !== l) @(negedge clk_i);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // a full frame with 20 us blanking is about 25k clocks
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            fails++;
            report_and_stop;
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        wb(12'h004, 0, 0);
        `CHK("mode1 reset", 8'h14, q[7:0])
        wb(12'h000, 0, 0);
        `CHK("mode0 reset", 8'h00, q[7:0])
        foreach (rows[i]) begin
            wb(rows[i].a, 1, rows[i].d);
            wb(rows[i].a, 0, 0);
            `CHK("register", rows[i].e, q[7:0])
        end
        $display("test registers done");
        for (int d = 0; d < 11; d++) begin
            wb(12'(12'h100 + 4 * (64 + d)), 1, 8'(8'ha0 + d));
            wb(12'(12'h100 + 4 * (48 + d)), 1, {d[1:0], 6'h15});
        end
        wb(12'h000, 1, 8'h01);
        wait_slot(1);
        @(negedge clk_i);
        `CHK("key pins", 40'h1008040201, pins)
        `CHK("key seg dig", 21'h0, {seg, dig})
        wb(12'h000, 0, 0);
        `CHK("flag set", 1'b1, q[7])
        wb(12'h000, 0, 0);
        `CHK("flag reread", 1'b1, q[7])
        `CHK("irq start", 1'b1, irq)
        wb(12'h020, 1, 8'h01);
        `CHK("irq cleared", 1'b0, irq)
        wb(12'h014, 1, 8'h3c);
        wb(12'h018, 1, 8'hc3);
        @(negedge clk_i);
        `CHK("rescan pins", 16'hc33c, pins[39:24])
        wait_slot(0);
        wb(12'h000, 0, 0);
        `CHK("flag clear", 8'h01, q[7:0])
        wb(12'h020, 0, 0);
        `CHK("end event", 8'h02, q[7:0])
        wb(12'h020, 1, 8'h03);
        $display("test key slot done");
        wait_slot(1);
        for (int d = 0; d < 11; d++) begin
            `CHK("segments", {8'(8'ha0 + d), 2'(d)}, lit[d])
        end
        $display("test frame done");
        wb(12'h000, 1, 8'h00);
        @(negedge clk_i);
        `CHK("abort idle", 22'h0, {slot, seg, dig})
        wb(12'h020, 0, 0);
        `CHK("abort events", 8'h03, q[7:0])
        `CHK("irq on", 1'b1, irq)
        wb(12'h024, 1, 8'h00);
        `CHK("irq masked", 1'b0, irq)
        $display("test abort done");
        report_and_stop;
    end
endmodule
`default_nettype wire
